// *** design/ccr_pkg.sv ***
package ccr_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  // Printed offsets are word indices; the byte address is four times these
  localparam logic [7:0] OFS_IDX_UPPER = 8'h1e;
  localparam logic [7:0] OFS_IDX_LOWER = 8'h1f;
  localparam logic [7:0] GAIN_IDX_UPPER = 8'h20;
  localparam logic [7:0] GAIN_IDX_LOWER = 8'h21;
  localparam logic [7:0] SETUP_IDX = 8'h22;
  // Own additions: status words that show the assembled values
  localparam logic [7:0] OFS_STAT_IDX = 8'h30;
  localparam logic [7:0] GAIN_STAT_IDX = 8'h31;
  localparam int ADDR_W = 10;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] OFS_UPPER_RST = 16'h0000;
  localparam logic [7:0] OFS_LOWER_RST = 8'h00;
  localparam logic [15:0] GAIN_UPPER_RST = 16'h8000;
  localparam logic [7:0] GAIN_LOWER_RST = 8'h00;
  localparam logic [9:0] PHASE_RST = 10'h000;
  localparam logic DCB_OFF_RST = 1'b0;

  // ----------------------------------------
  // Field positions of the setup word and of the lower offset and gain words
  // ----------------------------------------
  localparam int PHASE_HI = 15;
  localparam int PHASE_LO = 6;
  localparam int DCB_OFF_BIT = 2;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  localparam int LOW_HI = 15;
  localparam int LOW_LO = 8;

  // Input selector encodings
  typedef enum logic [1:0] {
    CCR_SEL_PINS = 2'h0,
    CCR_SEL_SHORT = 2'h1,
    CCR_SEL_POS_TEST = 2'h2,
    CCR_SEL_NEG_TEST = 2'h3
  } ccr_sel_e;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ccr_pkg

// *** design/ccr_regs.sv ***
// Summary of operation
// - Upper offset word holds offset bits 23:8
// - Lower offset word bits 15:8 hold 7:0
// - Offset value is signed two's complement
// - Upper offset word resets to zero
// - Upper gain word holds gain bits 23:8
// - Lower gain bits 15:8; 7:0 reserved
// - Gain value unsigned, zero to below two
// - Upper gain resets 8000h, lower zero
// - Phase delay ten bits at 15:6
// - Phase delay signed modulator cycle count
// - Bit 2 disables channel DC block
// - Bits 1:0 select channel five input
// - Selector resets to channel pins
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ccr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Calibration values to the datapath
  output logic signed [23:0] ch4_offset_value,
  output logic [23:0] ch4_gain_value,
  output logic ch4_gain_unity,
  // Channel five setup to the datapath
  output logic signed [9:0] ch5_phase_delay,
  output logic ch5_dc_block_off,
  output logic [1:0] ch5_input_select,
  // Global DC block enable and effective result for channel five
  input wire logic global_dc_block_setting,
  output logic ch5_dc_block_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [9:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ch4_offset_high_field;
    logic [7:0] ch4_offset_low_field;
    logic [15:0] ch4_gain_high_field;
    logic [7:0] ch4_gain_low_field;
    logic [9:0] ch5_phase_delay;
    logic ch5_dc_block_off;
    logic [1:0] ch5_input_select;
    logic gsync1;
    logic gsync2;
    logic dcb_active;
    logic awready;
    logic wready;
    logic arready;
    logic gain_unity;
  } ccr_state_s;

  ccr_state_s st_reg;
  ccr_state_s st_next;

  // Word index of a byte address; non-aligned low bits are ignored
  function automatic logic [7:0] ccr_index(input logic [9:0] addr);
    ccr_index = addr[9:2];
  endfunction : ccr_index

  // True when the index names a register of this bank
  function automatic logic ccr_mapped(input logic [7:0] idx);
    ccr_mapped = (idx == ccr_pkg::OFS_IDX_UPPER) ||
                 (idx == ccr_pkg::OFS_IDX_LOWER) ||
                 (idx == ccr_pkg::GAIN_IDX_UPPER) ||
                 (idx == ccr_pkg::GAIN_IDX_LOWER) ||
                 (idx == ccr_pkg::SETUP_IDX) ||
                 (idx == ccr_pkg::OFS_STAT_IDX) ||
                 (idx == ccr_pkg::GAIN_STAT_IDX);
  endfunction : ccr_mapped

  // Merge write data into a 16-bit word by byte strobes
  function automatic logic [15:0] ccr_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
    ccr_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : ccr_merge

  // Assembled 24-bit values and the 16-bit setup word
  logic [23:0] ofs_full;
  logic [23:0] gain_full;
  logic [15:0] setup_word;
  assign ofs_full = {st_reg.ch4_offset_high_field,
                     st_reg.ch4_offset_low_field};
  assign gain_full = {st_reg.ch4_gain_high_field,
                      st_reg.ch4_gain_low_field};
  // Reserved bits 5:3 read as zero
  assign setup_word = {st_reg.ch5_phase_delay, 3'h0,
                       st_reg.ch5_dc_block_off,
                       st_reg.ch5_input_select};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Write waits for both address and data so either order works
  always_comb begin
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [15:0] hw;
    widx = 8'h00;
    ridx = 8'h00;
    hw = 16'h0000;
    st_next = st_reg;
    st_next.gsync1 = global_dc_block_setting;
    st_next.gsync2 = st_reg.gsync1;
    // Per-channel disable overrides the global setting
    st_next.dcb_active = st_reg.gsync2 && !st_reg.ch5_dc_block_off;
    if (s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      widx = ccr_index(st_reg.aw_addr);
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = ccr_mapped(widx) ? ccr_pkg::RESP_OKAY
                                       : ccr_pkg::RESP_SLVERR;
      case (widx)
        ccr_pkg::OFS_IDX_UPPER: begin
          st_next.ch4_offset_high_field = ccr_merge(
            st_reg.ch4_offset_high_field, st_reg.w_data,
            st_reg.w_strb);
        end
        ccr_pkg::OFS_IDX_LOWER: begin
          if (st_reg.w_strb[1]) begin
            st_next.ch4_offset_low_field = st_reg.w_data[15:8];
          end
        end
        ccr_pkg::GAIN_IDX_UPPER: begin
          st_next.ch4_gain_high_field = ccr_merge(
            st_reg.ch4_gain_high_field, st_reg.w_data,
            st_reg.w_strb);
        end
        ccr_pkg::GAIN_IDX_LOWER: begin
          if (st_reg.w_strb[1]) begin
            st_next.ch4_gain_low_field = st_reg.w_data[15:8];
          end
        end
        ccr_pkg::SETUP_IDX: begin
          hw = ccr_merge(setup_word, st_reg.w_data, st_reg.w_strb);
          st_next.ch5_phase_delay =
            hw[ccr_pkg::PHASE_HI:ccr_pkg::PHASE_LO];
          st_next.ch5_dc_block_off = hw[ccr_pkg::DCB_OFF_BIT];
          st_next.ch5_input_select =
            hw[ccr_pkg::SEL_HI:ccr_pkg::SEL_LO];
        end
        default: begin
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read: one outstanding, data registered one cycle after address
    if (s_axi_arvalid && !st_reg.rvalid) begin
      ridx = ccr_index(s_axi_araddr);
      st_next.rvalid = 1'b1;
      st_next.rresp = ccr_mapped(ridx) ? ccr_pkg::RESP_OKAY
                                       : ccr_pkg::RESP_SLVERR;
      case (ridx)
        ccr_pkg::OFS_IDX_UPPER: st_next.rdata =
          {16'h0000, st_reg.ch4_offset_high_field};
        ccr_pkg::OFS_IDX_LOWER: st_next.rdata =
          {16'h0000, st_reg.ch4_offset_low_field, 8'h00};
        ccr_pkg::GAIN_IDX_UPPER: st_next.rdata =
          {16'h0000, st_reg.ch4_gain_high_field};
        ccr_pkg::GAIN_IDX_LOWER: st_next.rdata =
          {16'h0000, st_reg.ch4_gain_low_field, 8'h00};
        ccr_pkg::SETUP_IDX: st_next.rdata = {16'h0000, setup_word};
        // Sign-extended offset for software convenience
        ccr_pkg::OFS_STAT_IDX: st_next.rdata =
          {{8{ofs_full[23]}}, ofs_full};
        ccr_pkg::GAIN_STAT_IDX: st_next.rdata = {8'h00, gain_full};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (!reset_n) begin
      st_next = '0;
      st_next.ch4_offset_high_field = ccr_pkg::OFS_UPPER_RST;
      st_next.ch4_offset_low_field = ccr_pkg::OFS_LOWER_RST;
      st_next.ch4_gain_high_field = ccr_pkg::GAIN_UPPER_RST;
      st_next.ch4_gain_low_field = ccr_pkg::GAIN_LOWER_RST;
      st_next.ch5_phase_delay = ccr_pkg::PHASE_RST;
      st_next.ch5_dc_block_off = ccr_pkg::DCB_OFF_RST;
      st_next.ch5_input_select = ccr_pkg::CCR_SEL_PINS;
    end
    // Readies and unity flag kept in flops so no output is combinational
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    st_next.gain_unity = (st_next.ch4_gain_high_field ==
                          ccr_pkg::GAIN_UPPER_RST) &&
                         (st_next.ch4_gain_low_field ==
                          ccr_pkg::GAIN_LOWER_RST);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Synchronous reset folded into the next-state logic above
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  // Bus handshakes come straight from state flops
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  // Datapath views; offset signed, gain unsigned
  assign ch4_offset_value = $signed(ofs_full);
  assign ch4_gain_value = gain_full;
  // Half of full scale is unity gain
  assign ch4_gain_unity = st_reg.gain_unity;
  assign ch5_phase_delay = $signed(st_reg.ch5_phase_delay);
  assign ch5_dc_block_off = st_reg.ch5_dc_block_off;
  assign ch5_input_select = st_reg.ch5_input_select;
  assign ch5_dc_block_active = st_reg.dcb_active;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence setup_write_s;
    st_reg.aw_got && st_reg.w_got &&
      ccr_index(st_reg.aw_addr) == ccr_pkg::SETUP_IDX &&
      st_reg.w_strb[0];
  endsequence

  sequence ofs_upper_write_s;
    st_reg.aw_got && st_reg.w_got &&
      ccr_index(st_reg.aw_addr) == ccr_pkg::OFS_IDX_UPPER &&
      st_reg.w_strb[1:0] == 2'h3;
  endsequence

  sequence ofs_lower_write_s;
    st_reg.aw_got && st_reg.w_got &&
      ccr_index(st_reg.aw_addr) == ccr_pkg::OFS_IDX_LOWER &&
      st_reg.w_strb[1];
  endsequence

  sequence gain_upper_write_s;
    st_reg.aw_got && st_reg.w_got &&
      ccr_index(st_reg.aw_addr) == ccr_pkg::GAIN_IDX_UPPER &&
      st_reg.w_strb[1:0] == 2'h3;
  endsequence

  sequence phase_write_s;
    st_reg.aw_got && st_reg.w_got &&
      ccr_index(st_reg.aw_addr) == ccr_pkg::SETUP_IDX &&
      st_reg.w_strb[1:0] == 2'h3;
  endsequence

  ofs_reset_zero_a: assert property (@(posedge core_clk)
    !reset_n |=> ch4_offset_value == 24'sh000000)
    else $error("offset not zero after reset");

  gain_reset_half_a: assert property (@(posedge core_clk)
    !reset_n |=> ch4_gain_value == 24'h800000 && ch4_gain_unity)
    else $error("gain not 800000h after reset");

  sel_reset_pins_a: assert property (@(posedge core_clk)
    !reset_n |=> ch5_input_select == 2'h0 && ch5_phase_delay == 10'sh000)
    else $error("setup not cleared by reset");

  low_rsvd_zero_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_axi_rvalid && s_axi_rresp == 2'h0 &&
      $past(s_axi_arvalid && s_axi_arready) &&
      ccr_index($past(s_axi_araddr)) == ccr_pkg::GAIN_IDX_LOWER
      |-> s_axi_rdata[7:0] == 8'h00)
    else $error("reserved gain bits not zero");

  sel_write_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    setup_write_s |=> ch5_input_select == $past(st_reg.w_data[1:0]) &&
      ch5_dc_block_off == $past(st_reg.w_data[2]))
    else $error("setup write not applied");

  dcb_gate_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ch5_dc_block_off |=> !ch5_dc_block_active)
    else $error("dc block active while disabled");

  ofs_join_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ofs_upper_write_s |=>
      ch4_offset_value[23:8] == $past(st_reg.w_data[15:0]))
    else $error("upper offset write not applied");

  ofs_low_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ofs_lower_write_s |=>
      ch4_offset_value[7:0] == $past(st_reg.w_data[15:8]))
    else $error("lower offset write not applied");

  gain_high_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    gain_upper_write_s |=>
      ch4_gain_value[23:8] == $past(st_reg.w_data[15:0]))
    else $error("upper gain write not applied");

  phase_write_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    phase_write_s |=>
      ch5_phase_delay == $past(st_reg.w_data[15:6]))
    else $error("phase delay write not applied");

  wr_resp_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    st_reg.aw_got && st_reg.w_got |=> s_axi_bvalid)
    else $error("write response missing");

endmodule : ccr_regs

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk, reset_n;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic signed [23:0] ch4_offset_value;
  logic [23:0] ch4_gain_value;
  logic ch4_gain_unity, ch5_dc_block_off, global_dc_block_setting;
  logic signed [9:0] ch5_phase_delay;
  logic [1:0] ch5_input_select;
  logic ch5_dc_block_active;
  logic [7:0] ri;
  int err_total, tests_run;
  integer seed = 32'h5cfc;
  // Shadow copy of what the registers should hold
  logic [15:0] m_ou, m_gu, m_setup;
  logic [7:0] m_ol, m_gl;

  ccr_regs dut (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ch4_offset_value(ch4_offset_value),
    .ch4_gain_value(ch4_gain_value), .ch4_gain_unity(ch4_gain_unity),
    .ch5_phase_delay(ch5_phase_delay), .ch5_dc_block_off(ch5_dc_block_off),
    .ch5_input_select(ch5_input_select),
    .global_dc_block_setting(global_dc_block_setting),
    .ch5_dc_block_active(ch5_dc_block_active)
  );

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  // Byte lanes 0 and 1 only; upper strobes carry nothing here
  function automatic logic [15:0] merge(input logic [15:0] o,
      input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  function automatic logic [31:0] exp_word(input logic [7:0] idx);
    case (idx)
      ccr_pkg::OFS_IDX_UPPER: exp_word = {16'h0000, m_ou};
      ccr_pkg::OFS_IDX_LOWER: exp_word = {16'h0000, m_ol, 8'h00};
      ccr_pkg::GAIN_IDX_UPPER: exp_word = {16'h0000, m_gu};
      ccr_pkg::GAIN_IDX_LOWER: exp_word = {16'h0000, m_gl, 8'h00};
      ccr_pkg::SETUP_IDX: exp_word = {16'h0000, m_setup};
      ccr_pkg::OFS_STAT_IDX: exp_word = {{8{m_ou[15]}}, m_ou, m_ol};
      ccr_pkg::GAIN_STAT_IDX: exp_word = {8'h00, m_gu, m_gl};
      default: exp_word = 32'h0000_0000;
    endcase
  endfunction : exp_word

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: response %h exp %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Each half is released at its own handshake edge
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge so strobes are never assigned twice in a step
    @(posedge core_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
      output logic [1:0] r);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_read

  task automatic read_chk(input logic [7:0] idx);
    axi_read(idx, rd, rr);
    chk_resp(rr, ccr_pkg::RESP_OKAY);
    chk_val(rd, exp_word(idx), "read back");
  endtask : read_chk

  // Every readable word, then the datapath outputs once settled
  task automatic check_all;
    global_dc_block_setting <= 1'($random(seed));
    read_chk(ccr_pkg::OFS_IDX_UPPER);
    read_chk(ccr_pkg::OFS_IDX_LOWER);
    read_chk(ccr_pkg::GAIN_IDX_UPPER);
    read_chk(ccr_pkg::GAIN_IDX_LOWER);
    read_chk(ccr_pkg::SETUP_IDX);
    read_chk(ccr_pkg::OFS_STAT_IDX);
    read_chk(ccr_pkg::GAIN_STAT_IDX);
    #1;
    chk_val({8'h00, ch4_offset_value}, {8'h00, m_ou, m_ol}, "ofs");
    chk_val({8'h00, ch4_gain_value}, {8'h00, m_gu, m_gl}, "gain");
    chk_val({31'h0, ch4_gain_unity},
      {31'h0, {m_gu, m_gl} == 24'h800000}, "unity");
    chk_val({22'h0, ch5_phase_delay}, {22'h0, m_setup[15:6]}, "ph");
    chk_val({31'h0, ch5_dc_block_off}, {31'h0, m_setup[2]}, "off");
    chk_val({30'h0, ch5_input_select}, {30'h0, m_setup[1:0]}, "sel");
    chk_val({31'h0, ch5_dc_block_active},
      {31'h0, global_dc_block_setting & ~m_setup[2]}, "act");
    // Back on a rising edge so the next request starts there
    @(posedge core_clk);
  endtask : check_all

  // Write one mapped word, track it, and check everything
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] w;
    logic [15:0] v;
    w = exp_word(idx);
    v = merge(w[15:0], d, s);
    case (idx)
      ccr_pkg::OFS_IDX_UPPER: m_ou = v;
      ccr_pkg::OFS_IDX_LOWER: m_ol = v[15:8];
      ccr_pkg::GAIN_IDX_UPPER: m_gu = v;
      ccr_pkg::GAIN_IDX_LOWER: m_gl = v[15:8];
      default: m_setup = v & 16'hffc7;
    endcase
    axi_write(idx, d, s, rr);
    chk_resp(rr, ccr_pkg::RESP_OKAY);
    check_all();
  endtask : wr_reg

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    m_ou = 16'h0000;
    m_ol = 8'h00;
    m_gu = 16'h8000;
    m_gl = 8'h00;
    m_setup = 16'h0000;
    @(posedge core_clk);
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    global_dc_block_setting = 1'b0;
    err_total = 0;
    tests_run = 0;
    do_reset();
    check_all();
    // Corners: offset sign bit, full gain, reserved low byte, one lane
    wr_reg(ccr_pkg::OFS_IDX_UPPER, 32'h0000_8001, 4'hf);
    wr_reg(ccr_pkg::OFS_IDX_LOWER, 32'hffff_ffff, 4'h3);
    wr_reg(ccr_pkg::GAIN_IDX_UPPER, 32'h0000_ffff, 4'h3);
    wr_reg(ccr_pkg::GAIN_IDX_LOWER, 32'h0000_ff5a, 4'h3);
    wr_reg(ccr_pkg::OFS_IDX_UPPER, 32'h0000_7fee, 4'h2);
    // Every selector code with the block disable both ways
    for (int k = 0; k < 8; k++) begin
      wr_reg(ccr_pkg::SETUP_IDX,
        {16'h0000, 10'h201 + 10'(k), 3'h7, 3'(k)}, 4'h3);
    end
    for (int k = 0; k < 12; k++) begin
      ri = ccr_pkg::OFS_IDX_UPPER + 8'($unsigned($random(seed)) % 5);
      wr_reg(ri, $random(seed), 4'($random(seed)));
    end
    // Unmapped word answers with an error, status word ignores writes
    axi_write(8'h40, 32'hffff_ffff, 4'hf, rr);
    chk_resp(rr, ccr_pkg::RESP_SLVERR);
    axi_read(8'h40, rd, rr);
    chk_resp(rr, ccr_pkg::RESP_SLVERR);
    chk_val(rd, 32'h0000_0000, "unmapped data");
    axi_write(ccr_pkg::OFS_STAT_IDX, 32'h1234_5678, 4'hf, rr);
    chk_resp(rr, ccr_pkg::RESP_OKAY);
    check_all();
    // Second reset in mid-run restores the defaults
    do_reset();
    check_all();
    report_and_stop();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #(20000 * 50);
    err_total++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
